// *** sat_checker.sv ***
// port assertions for the scheduled action trigger
`timescale 1ns/1ps
module sat_checker
    import sat_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SAT_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cmd_valid,
    input wire logic cmd_scheduled,
    input wire logic cmd_ack_req,
    input wire logic ptp_enabled,
    input wire logic ptp_locked,
    input wire logic exposure_trigger,
    input wire logic ack_valid,
    input wire logic [2:0] ack_status
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    property p_apb_answer;
        s_setup ##1 s_access |-> pready;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    property p_wr_rdata;
        pready && pwrite |-> prdata == '0;
    endproperty
    property p_ack_cause;
        ack_valid |-> $past(cmd_valid && cmd_ack_req);
    endproperty
    property p_noref_code;
        cmd_valid && cmd_ack_req && cmd_scheduled
            && !(ptp_enabled && ptp_locked)
            |=> !ack_valid || ack_status == 3'h1;
    endproperty
    property p_noref_cause;
        ack_valid && ack_status == 3'h1
            |-> $past(cmd_scheduled && !(ptp_enabled && ptp_locked));
    endproperty
    property p_late_fires;
        ack_valid && ack_status == 3'h2 |-> exposure_trigger;
    endproperty
    property p_imm_fires;
        ack_valid && ack_status == 3'h0 && !$past(cmd_scheduled)
            |-> exposure_trigger;
    endproperty
    property p_ovf_sched;
        ack_valid && ack_status == 3'h3 |-> $past(cmd_scheduled);
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("no ready in access cycle");
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held too long");
    a_err_ready: assert property (p_err_ready)
        else $error("error without ready");
    a_wr_rdata: assert property (p_wr_rdata)
        else $error("read data on write");
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    a_noref_code: assert property (p_noref_code)
        else $error("wrong status without sync");
    a_noref_cause: assert property (p_noref_cause)
        else $error("no-ref status with sync");
    a_late_fires: assert property (p_late_fires)
        else $error("late command did not fire");
    a_imm_fires: assert property (p_imm_fires)
        else $error("immediate command did not fire");
    a_ovf_sched: assert property (p_ovf_sched)
        else $error("overflow on immediate command");
endmodule

bind sat_top sat_checker chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .cmd_valid, .cmd_scheduled, .cmd_ack_req, .ptp_enabled, .ptp_locked,
    .exposure_trigger, .ack_valid, .ack_status
);

// *** sat_host_model.sv ***
// host model that sends action commands
`timescale 1ns/1ps
module sat_host_model
    import sat_pkg::*;
(
    input wire logic pclk,
    output logic cmd_valid,
    output logic [SAT_DATA_W-1:0] cmd_device_key,
    output logic [SAT_DATA_W-1:0] cmd_group_key,
    output logic [SAT_DATA_W-1:0] cmd_group_mask,
    output logic cmd_scheduled,
    output logic [SAT_TIME_W-1:0] cmd_time_tag,
    output logic cmd_ack_req
);
    initial begin
        cmd_valid = 1'b0;
        {cmd_device_key, cmd_group_key, cmd_group_mask} = '0;
        {cmd_scheduled, cmd_time_tag, cmd_ack_req} = '0;
    end
    // one-cycle command; an idle edge always follows before the next one
    task automatic send(input logic [31:0] dk, input logic [31:0] gk,
            input logic [31:0] gm, input logic sch,
            input logic [63:0] tag, input logic ack);
        @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd_device_key <= dk;
        cmd_group_key <= gk;
        cmd_group_mask <= gm;
        cmd_scheduled <= sch;
        cmd_time_tag <= tag;
        cmd_ack_req <= ack;
        @(posedge pclk);
        cmd_valid <= 1'b0;
        // inverted fields when idle, so a stale match cannot pass unseen
        cmd_device_key <= ~dk;
        cmd_group_key <= ~gk;
        cmd_group_mask <= ~gm;
        cmd_time_tag <= ~tag;
    endtask
endmodule

// *** sat_pkg.sv ***
// constants, register map and state type of the scheduled action trigger
package sat_pkg;

    localparam int unsigned SAT_DATA_W = 32;
    localparam int unsigned SAT_TIME_W = 64;
    localparam int unsigned SAT_QDEPTH = 4;
    localparam int unsigned SAT_CNT_W = 3;
    localparam int unsigned SAT_SEL_W = 8;

    // register byte offsets
    localparam logic [7:0] SAT_CTRL_OFS = 8'h00;
    localparam logic [7:0] SAT_DEVKEY_OFS = 8'h04;
    localparam logic [7:0] SAT_SELECT_OFS = 8'h08;
    localparam logic [7:0] SAT_GRPKEY_OFS = 8'h0C;
    localparam logic [7:0] SAT_GRPMASK_OFS = 8'h10;
    localparam logic [7:0] SAT_CAPACITY_OFS = 8'h14;
    localparam logic [7:0] SAT_STATUS_OFS = 8'h18;
    localparam logic [7:0] SAT_LATENCY_OFS = 8'h1C;
    localparam logic [7:0] SAT_TRIGCNT_OFS = 8'h20;
    localparam logic [7:0] SAT_DROPCNT_OFS = 8'h24;
    localparam logic [7:0] SAT_REJCNT_OFS = 8'h28;

    // field positions
    localparam int unsigned SAT_CTRL_ACCEPT_BIT = 0;
    localparam int unsigned SAT_CTRL_FLUSH_BIT = 1;
    localparam int unsigned SAT_STAT_COUNT_LSB = 0;
    localparam int unsigned SAT_STAT_LOCK_BIT = 4;
    localparam int unsigned SAT_STAT_LAST_LSB = 8;

    // reset values
    localparam logic [SAT_DATA_W-1:0] SAT_KEY_RST = 32'h0000_0000;
    localparam logic [SAT_DATA_W-1:0] SAT_MASK_RST = 32'h0000_0000;
    localparam logic [SAT_SEL_W-1:0] SAT_SEL_RST = 8'h00;
    localparam logic [SAT_SEL_W-1:0] SAT_SEL_ACTION0 = 8'h00;
    localparam logic SAT_ACCEPT_RST = 1'b0;

    // fixed internal latency from trigger to exposure start, in ns
    localparam logic [SAT_TIME_W-1:0] SAT_LATENCY_NS = 64'h0000_0000_0000_0064;

    localparam logic [SAT_DATA_W-1:0] SAT_CAPACITY =
        SAT_DATA_W'(SAT_QDEPTH);

    typedef enum logic [2:0] {
        SAT_ACK_SUCCESS,
        SAT_ACK_NO_REF_TIME,
        SAT_ACK_ACTION_LATE,
        SAT_ACK_OVERFLOW
    } sat_ack_t;

    typedef struct packed {
        logic [SAT_QDEPTH-1:0] q_valid;
        logic [SAT_QDEPTH-1:0][SAT_TIME_W-1:0] q_tag;
        logic accept_closed;
        logic [SAT_DATA_W-1:0] dev_key;
        logic [SAT_DATA_W-1:0] grp_key;
        logic [SAT_DATA_W-1:0] grp_mask;
        logic [SAT_SEL_W-1:0] sel;
        logic [SAT_DATA_W-1:0] trig_cnt;
        logic [SAT_DATA_W-1:0] drop_cnt;
        logic [SAT_DATA_W-1:0] rej_cnt;
        sat_ack_t last_status;
        logic trig;
        logic ack_valid;
        sat_ack_t ack_status;
        logic pready;
        logic pslverr;
        logic [SAT_DATA_W-1:0] prdata;
    } sat_state_t;

endpackage

// *** sat_top.sv ***
// scheduled action trigger: command check, time queue and apb registers
`timescale 1ns/1ps

// Summary of operation
// - one action exists, defined by device key, group key and group mask
// - a trigger follows only a command whose fields match the action
// - scheduled command fields are checked in this logic, not software
// - device key is write-only, reads zero, and is the device credential
// - group key is read/write and compared with the command group key
// - group mask is read/write and ANDed with the command mask
// - selector picks which action the group key and mask accesses hit
// - closed-channel accept bit lets commands pass with no control channel
// - unicast and broadcast commands are accepted alike
// - time tags and comparisons are in nanoseconds
// - scheduled commands need time sync enabled and locked, else dropped
// - a validated scheduled command already late fires at once
// - future scheduled commands wait in a queue of four entries
// - with the queue full further scheduled commands are dropped
// - a due entry leaves the queue and raises the exposure trigger
// - a scheduled command with no reference time and acknowledge requested answers no-ref-time
// - a late scheduled command with acknowledge answers action-late
// - a scheduled command into a full queue answers overflow
// - a fixed internal latency is taken off each scheduled time tag
// - queue capacity reads as a read-only value
module sat_top
    import sat_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [SAT_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [SAT_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmd_valid,
    input wire logic [SAT_DATA_W-1:0] cmd_device_key,
    input wire logic [SAT_DATA_W-1:0] cmd_group_key,
    input wire logic [SAT_DATA_W-1:0] cmd_group_mask,
    input wire logic cmd_scheduled,
    input wire logic [SAT_TIME_W-1:0] cmd_time_tag,
    input wire logic cmd_ack_req,
    input wire logic channel_open,
    input wire logic ptp_enabled,
    input wire logic ptp_locked,
    input wire logic [SAT_TIME_W-1:0] ref_time,
    output logic exposure_trigger,
    output logic ack_valid,
    output logic [2:0] ack_status
);

    sat_state_t s_q;
    sat_state_t s_d;

    // combinational helpers
    logic key_match;
    logic chan_ok;
    logic time_ok;
    logic [SAT_TIME_W-1:0] eff_tag;
    logic is_late;
    logic q_full;
    logic slot_found;
    logic [1:0] free_slot;
    logic fire_due;
    logic fire_now;
    logic drop_evt;
    logic rej_evt;
    logic [SAT_CNT_W-1:0] pend_cnt;
    logic apb_setup;
    logic apb_wr;
    logic [SAT_DATA_W-1:0] rd_val;
    logic rd_err;
    logic sel_ok;

    function automatic logic [SAT_DATA_W-1:0] lane_merge(
        input logic [SAT_DATA_W-1:0] old_v,
        input logic [SAT_DATA_W-1:0] new_v,
        input logic [3:0] strb
    );
        logic [SAT_DATA_W-1:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        // broadcast or unicast addressing is not looked at here
        key_match = (cmd_device_key == s_q.dev_key) &&
                    (cmd_group_key == s_q.grp_key) &&
                    ((cmd_group_mask & s_q.grp_mask) != '0);
        chan_ok = channel_open || s_q.accept_closed;
        time_ok = ptp_enabled && ptp_locked;
        // saturate so an early tag cannot wrap to the far future
        if (cmd_time_tag >= SAT_LATENCY_NS) begin
            eff_tag = cmd_time_tag - SAT_LATENCY_NS;
        end else begin
            eff_tag = '0;
        end
        is_late = eff_tag < ref_time;
        q_full = &s_q.q_valid;
        slot_found = 1'b0;
        free_slot = 2'd0;
        pend_cnt = '0;
        for (int i = 0; i < SAT_QDEPTH; i++) begin
            pend_cnt = pend_cnt + SAT_CNT_W'(s_q.q_valid[i]);
            if (!s_q.q_valid[i] && !slot_found) begin
                slot_found = 1'b1;
                free_slot = 2'(i);
            end
        end
        apb_setup = psel && !penable;
        apb_wr = psel && penable && s_q.pready && pwrite;
        sel_ok = s_q.sel == SAT_SEL_ACTION0;
    end

    // register read mux, evaluated in the setup cycle
    always_comb begin
        rd_val = '0;
        rd_err = 1'b0;
        case (paddr)
            SAT_CTRL_OFS: begin
                rd_val[SAT_CTRL_ACCEPT_BIT] = s_q.accept_closed;
            end
            SAT_DEVKEY_OFS: begin
                rd_val = '0;
            end
            SAT_SELECT_OFS: begin
                rd_val[SAT_SEL_W-1:0] = s_q.sel;
            end
            SAT_GRPKEY_OFS: begin
                rd_val = sel_ok ? s_q.grp_key : '0;
            end
            SAT_GRPMASK_OFS: begin
                rd_val = sel_ok ? s_q.grp_mask : '0;
            end
            SAT_CAPACITY_OFS: begin
                rd_val = SAT_CAPACITY;
            end
            SAT_STATUS_OFS: begin
                rd_val[SAT_STAT_COUNT_LSB +: SAT_CNT_W] = pend_cnt;
                rd_val[SAT_STAT_LOCK_BIT] = time_ok;
                rd_val[SAT_STAT_LAST_LSB +: 3] = s_q.last_status;
            end
            SAT_LATENCY_OFS: begin
                rd_val = SAT_LATENCY_NS[SAT_DATA_W-1:0];
            end
            SAT_TRIGCNT_OFS: begin
                rd_val = s_q.trig_cnt;
            end
            SAT_DROPCNT_OFS: begin
                rd_val = s_q.drop_cnt;
            end
            SAT_REJCNT_OFS: begin
                rd_val = s_q.rej_cnt;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.trig = 1'b0;
        s_d.ack_valid = 1'b0;
        fire_due = 1'b0;
        fire_now = 1'b0;
        drop_evt = 1'b0;
        rej_evt = 1'b0;

        // due entries leave the queue; several due together give one pulse
        for (int i = 0; i < SAT_QDEPTH; i++) begin
            if (s_q.q_valid[i] && (s_q.q_tag[i] <= ref_time)) begin
                s_d.q_valid[i] = 1'b0;
                fire_due = 1'b1;
            end
        end

        if (cmd_valid) begin
            if (!chan_ok || !key_match) begin
                rej_evt = 1'b1;
            end else if (!cmd_scheduled) begin
                fire_now = 1'b1;
                s_d.ack_valid = cmd_ack_req;
                s_d.ack_status = SAT_ACK_SUCCESS;
                s_d.last_status = SAT_ACK_SUCCESS;
            end else if (!time_ok) begin
                drop_evt = 1'b1;
                s_d.ack_valid = cmd_ack_req;
                s_d.ack_status = SAT_ACK_NO_REF_TIME;
                s_d.last_status = SAT_ACK_NO_REF_TIME;
            end else if (is_late) begin
                fire_now = 1'b1;
                s_d.ack_valid = cmd_ack_req;
                s_d.ack_status = SAT_ACK_ACTION_LATE;
                s_d.last_status = SAT_ACK_ACTION_LATE;
            end else if (q_full) begin
                // a slot freed this same cycle is not reused until next
                drop_evt = 1'b1;
                s_d.ack_valid = cmd_ack_req;
                s_d.ack_status = SAT_ACK_OVERFLOW;
                s_d.last_status = SAT_ACK_OVERFLOW;
            end else begin
                // checked and stored entirely in hardware
                s_d.q_valid[free_slot] = 1'b1;
                s_d.q_tag[free_slot] = eff_tag;
                s_d.ack_valid = cmd_ack_req;
                s_d.ack_status = SAT_ACK_SUCCESS;
                s_d.last_status = SAT_ACK_SUCCESS;
            end
        end

        s_d.trig = fire_due || fire_now;
        if (s_d.trig) begin
            s_d.trig_cnt = s_q.trig_cnt + 32'h0000_0001;
        end
        if (drop_evt) begin
            s_d.drop_cnt = s_q.drop_cnt + 32'h0000_0001;
        end
        if (rej_evt) begin
            s_d.rej_cnt = s_q.rej_cnt + 32'h0000_0001;
        end

        // apb: answer one cycle after setup, with no wait states
        s_d.pready = apb_setup;
        if (apb_setup) begin
            s_d.pslverr = rd_err;
            s_d.prdata = pwrite ? '0 : rd_val;
        end else if (psel && penable && s_q.pready) begin
            s_d.pslverr = 1'b0;
            s_d.prdata = '0;
        end

        if (apb_wr && !s_q.pslverr) begin
            case (paddr)
                SAT_CTRL_OFS: begin
                    if (pstrb[0]) begin
                        s_d.accept_closed = pwdata[SAT_CTRL_ACCEPT_BIT];
                        // flush wins over an insert in the same cycle
                        if (pwdata[SAT_CTRL_FLUSH_BIT]) begin
                            s_d.q_valid = '0;
                        end
                    end
                end
                SAT_DEVKEY_OFS: begin
                    s_d.dev_key = lane_merge(s_q.dev_key, pwdata, pstrb);
                end
                SAT_SELECT_OFS: begin
                    if (pstrb[0]) begin
                        s_d.sel = pwdata[SAT_SEL_W-1:0];
                    end
                end
                SAT_GRPKEY_OFS: begin
                    if (sel_ok) begin
                        s_d.grp_key = lane_merge(s_q.grp_key, pwdata, pstrb);
                    end
                end
                SAT_GRPMASK_OFS: begin
                    if (sel_ok) begin
                        s_d.grp_mask =
                            lane_merge(s_q.grp_mask, pwdata, pstrb);
                    end
                end
                default: begin
                    // read-only or unmapped: no effect
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.q_valid <= '0;
            s_q.q_tag <= '0;
            s_q.accept_closed <= SAT_ACCEPT_RST;
            s_q.dev_key <= SAT_KEY_RST;
            s_q.grp_key <= SAT_KEY_RST;
            s_q.grp_mask <= SAT_MASK_RST;
            s_q.sel <= SAT_SEL_RST;
            s_q.trig_cnt <= '0;
            s_q.drop_cnt <= '0;
            s_q.rej_cnt <= '0;
            s_q.last_status <= SAT_ACK_SUCCESS;
            s_q.trig <= 1'b0;
            s_q.ack_valid <= 1'b0;
            s_q.ack_status <= SAT_ACK_SUCCESS;
            s_q.pready <= 1'b0;
            s_q.pslverr <= 1'b0;
            s_q.prdata <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign exposure_trigger = s_q.trig;
    assign ack_valid = s_q.ack_valid;
    assign ack_status = s_q.ack_status;

endmodule

// *** tb_top.sv ***
// self-checking bench of the scheduled action trigger
`timescale 1ns/1ps
module tb_top
    import sat_pkg::*;
;
    logic pclk, pready, pslverr, exposure_trigger, ack_valid, a;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic channel_open = 1'b0, ptp_enabled = 1'b0, ptp_locked = 1'b0;
    logic clk_en = 1'b1;
    logic [3:0] pstrb = 4'hF;
    logic cmd_valid, cmd_scheduled, cmd_ack_req;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, cmd_device_key, cmd_group_key, cmd_group_mask;
    logic [31:0] dk, gk, gm, rk;
    logic [63:0] ref_time = 64'h0, cmd_time_tag, base;
    logic [2:0] ack_status;
    logic [2:0] exp_ack[$];
    logic [32:0] exp_rd[$];
    bit exp_trig[$];
    int err_total, comparisons, cyc, k;

    sat_top uut (
        .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .cmd_valid,
        .cmd_device_key, .cmd_group_key, .cmd_group_mask, .cmd_scheduled,
        .cmd_time_tag, .cmd_ack_req, .channel_open, .ptp_enabled,
        .ptp_locked, .ref_time, .exposure_trigger, .ack_valid, .ack_status
    );
    sat_host_model host (
        .pclk, .cmd_valid, .cmd_device_key, .cmd_group_key, .cmd_group_mask,
        .cmd_scheduled, .cmd_time_tag, .cmd_ack_req
    );

    task automatic final_report;
        if (err_total == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    function automatic void chk(logic ok, string m);
        comparisons++;
        if (!ok) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endfunction
    task automatic apb(input logic wr, input logic [7:0] ad,
            input logic [31:0] d, input logic [32:0] e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        exp_rd.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // watchdog; the whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            final_report();
        end
    end
    always @(posedge pclk) begin
        if (presetn === 1'b1) begin
            if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
                chk(exp_rd.size() > 0 && {pslverr, prdata} === exp_rd[0],
                    "apb answer");
                if (exp_rd.size() > 0) exp_rd.delete(0);
            end
            if (ack_valid === 1'b1) begin
                chk(exp_ack.size() > 0 && ack_status === exp_ack[0], "ack");
                if (exp_ack.size() > 0) exp_ack.delete(0);
            end
            if (exposure_trigger === 1'b1) begin
                chk(exp_trig.size() > 0, "unexpected trigger");
                if (exp_trig.size() > 0) exp_trig.delete(0);
            end
        end
    end

    initial begin
        void'($urandom(32'h5B3A150F));
        dk = $urandom;
        gk = $urandom;
        gm = $urandom | 32'h1;
        base = 64'h0000_0000_0001_0000;
        ref_time = base;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, SAT_GRPMASK_OFS, 32'h0, 33'h0);
        apb(1'b1, SAT_DEVKEY_OFS, dk, 33'h0);
        apb(1'b1, SAT_GRPKEY_OFS, gk, 33'h0);
        apb(1'b1, SAT_GRPMASK_OFS, gm, 33'h0);
        apb(1'b0, SAT_DEVKEY_OFS, 32'h0, 33'h0);
        apb(1'b0, SAT_GRPKEY_OFS, 32'h0, {1'b0, gk});
        apb(1'b0, SAT_GRPMASK_OFS, 32'h0, {1'b0, gm});
        apb(1'b1, SAT_CAPACITY_OFS, 32'h9, 33'h0);
        apb(1'b0, SAT_CAPACITY_OFS, 32'h0, 33'h0_0000_0004);
        apb(1'b0, 8'h30, 32'h0, 33'h1_0000_0000);
        apb(1'b1, SAT_SELECT_OFS, 32'h1, 33'h0);
        apb(1'b0, SAT_GRPKEY_OFS, 32'h0, 33'h0);
        apb(1'b1, SAT_SELECT_OFS, 32'h0, 33'h0);
        // only the two low lanes take the new key bytes
        pstrb <= 4'h3;
        apb(1'b1, SAT_GRPKEY_OFS, ~gk, 33'h0);
        pstrb <= 4'hF;
        apb(1'b0, SAT_GRPKEY_OFS, 32'h0, {1'b0, gk[31:16], ~gk[15:0]});
        apb(1'b1, SAT_GRPKEY_OFS, gk, 33'h0);
        host.send(dk, gk, gm, 1'b0, 64'h0, 1'b1);
        channel_open <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            k = $urandom_range(3);
            rk = $urandom;
            a = 1'($urandom);
            if (k == 3) exp_trig.push_back(1'b1);
            if (k == 3 && a) exp_ack.push_back(3'h0);
            host.send(k == 0 ? dk ^ (rk | 32'h1) : dk,
                k == 1 ? gk ^ (rk | 32'h1) : gk,
                k == 2 ? ~gm & rk : gm | rk, 1'b0, 64'h0, a);
        end
        channel_open <= 1'b0;
        apb(1'b1, SAT_CTRL_OFS, 32'h1, 33'h0);
        exp_ack.push_back(3'h0);
        exp_trig.push_back(1'b1);
        host.send(dk, gk, gm, 1'b0, 64'h0, 1'b1);
        exp_ack.push_back(3'h1);
        host.send(dk, gk, gm, 1'b1, base + 64'd5000, 1'b1);
        ptp_enabled <= 1'b1;
        exp_ack.push_back(3'h1);
        host.send(dk, gk, gm, 1'b1, base + 64'd5000, 1'b1);
        ptp_locked <= 1'b1;
        exp_ack.push_back(3'h2);
        exp_trig.push_back(1'b1);
        host.send(dk, gk, gm, 1'b1, base + 64'd99, 1'b1);
        exp_ack.push_back(3'h0);
        exp_trig.push_back(1'b1);
        host.send(dk, gk, gm, 1'b1, base + 64'd100, 1'b1);
        host.send(dk ^ 32'h1, gk, gm, 1'b1, base + 64'd500, 1'b1);
        for (int i = 1; i <= 5; i++) begin
            exp_ack.push_back(i == 5 ? 3'h3 : 3'h0);
            host.send(dk, gk, gm, 1'b1, base + 64'(1000 * i), 1'b1);
        end
        apb(1'b0, SAT_STATUS_OFS, 32'h0, 33'h0_0000_0314);
        for (int i = 1; i <= 4; i++) begin
            @(posedge pclk);
            ref_time <= base + 64'(1000 * i) - 64'd101;
            repeat (3) @(posedge pclk);
            ref_time <= base + 64'(1000 * i) - 64'd100;
            if (i == 1) begin
                // frozen clock enable: a due entry must wait, no trigger yet
                clk_en <= 1'b0;
                repeat (4) @(posedge pclk);
                clk_en <= 1'b1;
            end
            exp_trig.push_back(1'b1);
            repeat (3) @(posedge pclk);
        end
        apb(1'b0, SAT_STATUS_OFS, 32'h0, 33'h0_0000_0310);
        repeat (4) @(posedge pclk);
        chk(exp_trig.size() + exp_ack.size() + exp_rd.size() == 0, "left");
        final_report();
    end
endmodule
